// *** core/pcg_ctrl.sv ***
// Clock generator control: registers, interlocks, dividers and output clock
// Function
// - Crystal clock runs at crystal rate and is buffered as loop reference.
// - Oscillator runs when integration enable is set outside stop, or run-in-stop bit is set.
// - Reference clock is divided by programmable factor R for the detector.
// - VCO clock is divided by two to the P, then by N, for feedback.
// - VCO centre is L times two to the E times 38.4 kHz.
// - Loop runs acquisition or tracking, switched automatically or by software.
// - Six registers: control, bandwidth, multiplier high/low, VCO range, divider.
// - With automatic mode off, lock interrupt enable stays clear, ignores writes.
// - With automatic mode off, lock-change flag and lock indicator read zero.
// - With automatic mode on, acquisition select is read-only.
// - Loop off or VCO range zero holds base clock select clear.
// - With loop power on, programming registers ignore writes.
// - Base clock select set forces loop power on and read-only.
// - Stop while VCO clock drives output clears base clock select.
// - Stop without run-in-stop disables oscillator and loop, outputs low.
// - Stop with run-in-stop shuts the loop but keeps the oscillator.
// - In break with clear enable low, control access keeps the lock flag.
//
// Local design decision: strobed register access.
module pcg_ctrl
	import pcg_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic XTAL_TICK_I,
	input wire logic VCO_TICK_I,
	input wire logic LOCK_I,
	input wire logic STOP_I,
	input wire logic BREAK_I,
	input wire logic BREAK_CLEAR_ENABLE_I,
	input wire logic INTEGRATION_OSC_ENABLE_I,
	input wire logic OSC_RUN_IN_STOP_I,
	output logic OSC_ENABLE_O,
	output logic PLL_ENABLE_O,
	output logic CRYSTAL_CLOCK_OUT_O,
	output logic DIVIDED_REFERENCE_CLOCK_O,
	output logic VCO_FEEDBACK_CLOCK_O,
	output logic GENERATOR_OUTPUT_CLOCK_O,
	output logic OUTPUT_FROM_VCO_O,
	output logic TRACKING_O,
	output logic LOCK_IRQ_O,
	output logic [7:0] VCO_RANGE_VALUE_O,
	output logic [1:0] VCO_RANGE_POWER_O
);
	logic ie_reg, ie_next;
	logic flag_reg, flag_next;
	logic on_reg, on_next;
	logic bcs_reg, bcs_next;
	logic [1:0] pre_reg, pre_next;
	logic [1:0] vpr_reg, vpr_next;
	logic auto_reg, auto_next;
	logic acq_n_reg, acq_n_next;
	logic [PCG_MUL_W-1:0] mul_reg, mul_next;
	logic [7:0] vrs_reg, vrs_next;
	logic [PCG_RDS_W-1:0] rds_reg, rds_next;
	logic lock_q_reg, lock_q_next;
	logic [7:0] rdata_reg, rdata_next;
	logic osc_en_reg, osc_en_next;
	logic pll_en_reg, pll_en_next;
	logic xclk_reg, xclk_next;
	logic irq_reg, irq_next;
	logic wr_ctrl, wr_bw, rd_ctrl, hold_out, pll_run, lock_eff, flag_set, flag_clr;
	logic vco_tick;
	logic [PCG_DIV_W-1:0] ref_div, fb_div;
	logic [PCG_MUL_W-1:0] n_eff;

	// Decode and qualified status
	always_comb
	begin
		wr_ctrl = WR_I && (ADDR_I == PCG_CTRL_ADDR);
		wr_bw = WR_I && (ADDR_I == PCG_BW_ADDR);
		rd_ctrl = RD_I && (ADDR_I == PCG_CTRL_ADDR);
		pll_run = on_reg && !STOP_I;
		lock_eff = LOCK_I && pll_run;
		hold_out = STOP_I && !OSC_RUN_IN_STOP_I;
		flag_set = auto_reg && (lock_eff != lock_q_reg);
		flag_clr = rd_ctrl && !(BREAK_I && !BREAK_CLEAR_ENABLE_I);
	end

	// Register file next state with interlocks
	always_comb
	begin
		ie_next = ie_reg;
		on_next = on_reg;
		bcs_next = bcs_reg;
		pre_next = pre_reg;
		vpr_next = vpr_reg;
		auto_next = auto_reg;
		acq_n_next = acq_n_reg;
		mul_next = mul_reg;
		vrs_next = vrs_reg;
		rds_next = rds_reg;
		if (!auto_reg)
			ie_next = 1'b0;
		else if (wr_ctrl)
			ie_next = WDATA_I[PCG_CTRL_IE_BIT];
		if (bcs_reg)
			on_next = 1'b1;
		else if (wr_ctrl)
			on_next = WDATA_I[PCG_CTRL_ON_BIT];
		if (!on_reg || (vrs_reg == 8'h00))
			bcs_next = 1'b0;
		else if (STOP_I && bcs_reg)
			bcs_next = 1'b0;
		else if (wr_ctrl)
			bcs_next = WDATA_I[PCG_CTRL_BCS_BIT];
		if (!on_reg)
		begin
			if (wr_ctrl)
			begin
				pre_next = WDATA_I[PCG_CTRL_PRE_LSB+:2];
				vpr_next = WDATA_I[PCG_CTRL_VPR_LSB+:2];
			end
			if (WR_I && (ADDR_I == PCG_MULH_ADDR))
				mul_next[11:8] = WDATA_I[3:0];
			if (WR_I && (ADDR_I == PCG_MULL_ADDR))
				mul_next[7:0] = WDATA_I;
			if (WR_I && (ADDR_I == PCG_VRS_ADDR))
				vrs_next = WDATA_I;
			if (WR_I && (ADDR_I == PCG_RDS_ADDR))
				rds_next = WDATA_I[PCG_RDS_W-1:0];
		end
		if (wr_bw)
			auto_next = WDATA_I[PCG_BW_AUTO_BIT];
		if (auto_reg)
			acq_n_next = lock_eff;
		else if (wr_bw)
			acq_n_next = WDATA_I[PCG_BW_ACQ_BIT];
	end

	// Lock-change flag: set wins over clear
	always_comb
	begin
		lock_q_next = lock_eff;
		if (!auto_reg)
			flag_next = 1'b0;
		else if (flag_set)
			flag_next = 1'b1;
		else if (flag_clr)
			flag_next = 1'b0;
		else
			flag_next = flag_reg;
	end

	// Read data, one cycle after the strobe
	always_comb
	begin
		rdata_next = 8'h00;
		if (RD_I)
		begin
			unique case (ADDR_I)
				PCG_CTRL_ADDR: rdata_next = {ie_reg, flag_reg && auto_reg, on_reg, bcs_reg, pre_reg, vpr_reg};
				PCG_BW_ADDR: rdata_next = {auto_reg, lock_q_reg && auto_reg, acq_n_reg, 5'h00};
				PCG_MULH_ADDR: rdata_next = {4'h0, mul_reg[11:8]};
				PCG_MULL_ADDR: rdata_next = mul_reg[7:0];
				PCG_VRS_ADDR: rdata_next = vrs_reg;
				PCG_RDS_ADDR: rdata_next = {4'h0, rds_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// Oscillator, loop and crystal clock
	always_comb
	begin
		osc_en_next = (INTEGRATION_OSC_ENABLE_I && !STOP_I) || OSC_RUN_IN_STOP_I;
		pll_en_next = pll_run;
		xclk_next = XTAL_TICK_I && osc_en_reg;
		irq_next = flag_next && ie_next;
		vco_tick = VCO_TICK_I && pll_en_reg;
		ref_div = (rds_reg == 4'h0) ? 15'h0001 : {11'h000, rds_reg};
		n_eff = (mul_reg == 12'h000) ? 12'h001 : mul_reg;
		fb_div = PCG_DIV_W'({3'h0, n_eff} << pre_reg);
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
		begin
			ie_reg <= PCG_CTRL_RST[PCG_CTRL_IE_BIT];
			flag_reg <= PCG_CTRL_RST[PCG_CTRL_FLAG_BIT];
			on_reg <= PCG_CTRL_RST[PCG_CTRL_ON_BIT];
			bcs_reg <= PCG_CTRL_RST[PCG_CTRL_BCS_BIT];
			pre_reg <= PCG_CTRL_RST[PCG_CTRL_PRE_LSB+:2];
			vpr_reg <= PCG_CTRL_RST[PCG_CTRL_VPR_LSB+:2];
			auto_reg <= PCG_BW_RST[PCG_BW_AUTO_BIT];
			acq_n_reg <= PCG_BW_RST[PCG_BW_ACQ_BIT];
			mul_reg <= {PCG_MULH_RST[3:0], PCG_MULL_RST};
			vrs_reg <= PCG_VRS_RST;
			rds_reg <= PCG_RDS_RST[PCG_RDS_W-1:0];
			lock_q_reg <= 1'b0;
			rdata_reg <= 8'h00;
			osc_en_reg <= 1'b0;
			pll_en_reg <= 1'b0;
			xclk_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			ie_reg <= ie_next;
			flag_reg <= flag_next;
			on_reg <= on_next;
			bcs_reg <= bcs_next;
			pre_reg <= pre_next;
			vpr_reg <= vpr_next;
			auto_reg <= auto_next;
			acq_n_reg <= acq_n_next;
			mul_reg <= mul_next;
			vrs_reg <= vrs_next;
			rds_reg <= rds_next;
			lock_q_reg <= lock_q_next;
			rdata_reg <= rdata_next;
			osc_en_reg <= osc_en_next;
			pll_en_reg <= pll_en_next;
			xclk_reg <= xclk_next;
			irq_reg <= irq_next;
		end
	end

	pcg_div u_ref_div (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.run_i(pll_en_reg),
		.tick_i(xclk_reg),
		.div_i(ref_div),
		.pulse_o(DIVIDED_REFERENCE_CLOCK_O)
	);

	pcg_div u_fb_div (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.run_i(pll_en_reg),
		.tick_i(vco_tick),
		.div_i(fb_div),
		.pulse_o(VCO_FEEDBACK_CLOCK_O)
	);

	pcg_clksw u_out_sw (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.hold_i(hold_out),
		.sel_i(bcs_reg),
		.tick_a_i(xclk_reg),
		.tick_b_i(vco_tick),
		.clk_o(GENERATOR_OUTPUT_CLOCK_O),
		.sel_o(OUTPUT_FROM_VCO_O)
	);

	assign RDATA_O = rdata_reg;
	assign OSC_ENABLE_O = osc_en_reg;
	assign PLL_ENABLE_O = pll_en_reg;
	assign CRYSTAL_CLOCK_OUT_O = xclk_reg;
	assign TRACKING_O = acq_n_reg;
	assign LOCK_IRQ_O = irq_reg;
	assign VCO_RANGE_VALUE_O = vrs_reg;
	assign VCO_RANGE_POWER_O = vpr_reg;

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	sequence lock_change_s;
		auto_reg && (lock_eff != lock_q_reg) && !wr_bw;
	endsequence
	sequence flag_raised_s;
		flag_reg ##1 (LOCK_IRQ_O == (flag_reg && ie_reg));
	endsequence

	ie_forced_clear_a: assert property (!auto_reg |=> !ie_reg)
		else $error("lock interrupt enable set while automatic mode off");
	status_read_zero_a: assert property (RD_I && !auto_reg && (ADDR_I == PCG_CTRL_ADDR || ADDR_I == PCG_BW_ADDR)
		|=> RDATA_O[6] == 1'b0)
		else $error("flag or lock read nonzero with automatic mode off");
	acq_follows_lock_a: assert property (auto_reg |=> acq_n_reg == $past(lock_eff))
		else $error("acquisition select not under hardware control");
	bcs_gate_a: assert property ((!on_reg || vrs_reg == 8'h00) |=> !bcs_reg)
		else $error("base clock select set while loop off or range zero");
	prog_lock_a: assert property (on_reg && WR_I |=> mul_reg == $past(mul_reg) && rds_reg == $past(rds_reg)
		&& vrs_reg == $past(vrs_reg))
		else $error("programming register changed with loop on");
	power_forced_a: assert property (bcs_reg |=> on_reg)
		else $error("loop power cleared while base clock select set");
	stop_bcs_clear_a: assert property (STOP_I && bcs_reg |=> !bcs_reg)
		else $error("base clock select survived stop");
	stop_osc_off_a: assert property (STOP_I && !OSC_RUN_IN_STOP_I |=> !OSC_ENABLE_O && !PLL_ENABLE_O ##1 !CRYSTAL_CLOCK_OUT_O)
		else $error("oscillator or loop running in stop");
	stop_osc_run_a: assert property (STOP_I && OSC_RUN_IN_STOP_I |=> OSC_ENABLE_O && !PLL_ENABLE_O)
		else $error("run-in-stop behaviour wrong");
	break_flag_kept_a: assert property (BREAK_I && !BREAK_CLEAR_ENABLE_I && flag_reg && auto_reg && !wr_bw |=> flag_reg)
		else $error("lock flag cleared during protected break");
	lock_flag_irq_a: assert property (lock_change_s |=> flag_raised_s)
		else $error("lock change did not raise flag and interrupt");
	prog_field_lock_a: assert property (on_reg && wr_ctrl
		|=> pre_reg == $past(pre_reg) && vpr_reg == $past(vpr_reg))
		else $error("prescaler or range power changed with loop on");
	out_held_low_a: assert property (hold_out |=> !GENERATOR_OUTPUT_CLOCK_O)
		else $error("output clock high in stop");
	irq_needs_enable_a: assert property (LOCK_IRQ_O |-> ie_reg && flag_reg)
		else $error("lock interrupt without flag and enable");
endmodule

// *** core/pcg_pkg.sv ***
// Constants shared by the clock generator control logic
package pcg_pkg;
	// Register addresses on the byte-wide register port
	localparam logic [7:0] PCG_CTRL_ADDR = 8'h36;
	localparam logic [7:0] PCG_BW_ADDR = 8'h37;
	localparam logic [7:0] PCG_MULH_ADDR = 8'h38;
	localparam logic [7:0] PCG_MULL_ADDR = 8'h39;
	localparam logic [7:0] PCG_VRS_ADDR = 8'h3A;
	localparam logic [7:0] PCG_RDS_ADDR = 8'h3B;
	// Reset values
	localparam logic [7:0] PCG_CTRL_RST = 8'h20;
	localparam logic [7:0] PCG_BW_RST = 8'h00;
	localparam logic [7:0] PCG_MULH_RST = 8'h00;
	localparam logic [7:0] PCG_MULL_RST = 8'h40;
	localparam logic [7:0] PCG_VRS_RST = 8'h40;
	localparam logic [7:0] PCG_RDS_RST = 8'h01;
	// Control register fields
	localparam int unsigned PCG_CTRL_IE_BIT = 7;
	localparam int unsigned PCG_CTRL_FLAG_BIT = 6;
	localparam int unsigned PCG_CTRL_ON_BIT = 5;
	localparam int unsigned PCG_CTRL_BCS_BIT = 4;
	localparam int unsigned PCG_CTRL_PRE_LSB = 2;
	localparam int unsigned PCG_CTRL_VPR_LSB = 0;
	// Bandwidth control register fields
	localparam int unsigned PCG_BW_AUTO_BIT = 7;
	localparam int unsigned PCG_BW_LOCK_BIT = 6;
	localparam int unsigned PCG_BW_ACQ_BIT = 5;
	// Field widths
	localparam int unsigned PCG_MUL_W = 12;
	localparam int unsigned PCG_RDS_W = 4;
	localparam int unsigned PCG_DIV_W = 15;
	// Nominal VCO centre step and system clock
	localparam int unsigned PCG_NOM_FREQ_HZ = 38400;
	localparam int unsigned PCG_CLK_FREQ_HZ = 50000000;
endpackage

// *** core/pcg_div.sv ***
// Programmable tick divider: one output pulse per div_i input ticks
module pcg_div
	import pcg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic tick_i,
	input wire logic [PCG_DIV_W-1:0] div_i,
	output logic pulse_o
);
	logic [PCG_DIV_W-1:0] cnt_reg;
	logic [PCG_DIV_W-1:0] cnt_next;
	logic pulse_reg;
	logic pulse_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		pulse_next = 1'b0;
		if (!run_i)
			cnt_next = '0;
		else if (tick_i)
		begin
			if (cnt_reg >= div_i - 15'h0001)
			begin
				cnt_next = '0;
				pulse_next = 1'b1;
			end
			else
				cnt_next = cnt_reg + 15'h0001;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_reg <= '0;
			pulse_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_o = pulse_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	div_pulse_cause_a: assert property (pulse_o |-> $past(tick_i) && $past(run_i))
		else $error("divider pulse without an input tick");
	div_stop_quiet_a: assert property (!run_i |=> !pulse_o)
		else $error("divider pulsed while stopped");
endmodule

// *** core/pcg_clksw.sv ***
// Glitch-free source switch producing the halved output clock
module pcg_clksw
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic hold_i,
	input wire logic sel_i,
	input wire logic tick_a_i,
	input wire logic tick_b_i,
	output logic clk_o,
	output logic sel_o
);
	logic out_reg;
	logic out_next;
	logic sel_reg;
	logic sel_next;
	logic cur_tick;

	always_comb
	begin
		cur_tick = sel_reg ? tick_b_i : tick_a_i;
		out_next = out_reg;
		sel_next = sel_reg;
		if (hold_i)
		begin
			out_next = 1'b0;
			// Source may only move once the output is already low
			if (!out_reg)
				sel_next = sel_i;
		end
		else if (!out_reg && (sel_i != sel_reg))
			sel_next = sel_i;
		else if (cur_tick)
			out_next = !out_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			out_reg <= 1'b0;
			sel_reg <= 1'b0;
		end
		else
		begin
			out_reg <= out_next;
			sel_reg <= sel_next;
		end
	end

	assign clk_o = out_reg;
	assign sel_o = sel_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sw_while_low_a: assert property ($changed(sel_o) |-> !$past(clk_o))
		else $error("clock source switched while output high");
	sw_edge_cause_a: assert property ($changed(clk_o) && !$past(hold_i) |->
		($past(sel_o) ? $past(tick_b_i) : $past(tick_a_i)))
		else $error("output clock edge without source tick");
endmodule

// *** tb/pcg_xtal_model.sv ***
// Crystal reference source model: one tick every PERIOD clocks while enabled
module pcg_xtal_model #(parameter int PERIOD = 4)
(
	input wire logic clk_i,
	input wire logic en_i,
	output logic tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial tick_o = 1'b0;
	// A disabled oscillator stands still
	always @(posedge clk_i)
	begin
		cnt <= (!en_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
		tick_o <= en_i && cnt == PERIOD - 1;
	end
endmodule

// *** tb/pcg_ctrl_tb.sv ***
// Self-checking bench for the clock generator control block
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
$display("Error %s expected %0h seen %0h", nm, e, g); end end
module pcg_ctrl_tb;
	import pcg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I = 0, RSTN_I = 0, WR_I = 0, RD_I = 0, VCO_TICK_I = 0, LOCK_I = 0, STOP_I = 0, BREAK_I = 0;
	logic BREAK_CLEAR_ENABLE_I = 0, INTEGRATION_OSC_ENABLE_I = 1, OSC_RUN_IN_STOP_I = 0;
	logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, RDATA_O, VCO_RANGE_VALUE_O;
	logic XTAL_TICK_I, OSC_ENABLE_O, PLL_ENABLE_O, CRYSTAL_CLOCK_OUT_O, DIVIDED_REFERENCE_CLOCK_O;
	logic VCO_FEEDBACK_CLOCK_O, GENERATOR_OUTPUT_CLOCK_O, OUTPUT_FROM_VCO_O, TRACKING_O, LOCK_IRQ_O;
	logic [1:0] VCO_RANGE_POWER_O;
	int miscompares = 0, n_checks = 0, cycles = 0, n;
	localparam logic [7:0] RST_TBL [6] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01};

	pcg_ctrl pcg_ctrl_inst (
		.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
		.RDATA_O(RDATA_O), .XTAL_TICK_I(XTAL_TICK_I), .VCO_TICK_I(VCO_TICK_I), .LOCK_I(LOCK_I),
		.STOP_I(STOP_I), .BREAK_I(BREAK_I), .BREAK_CLEAR_ENABLE_I(BREAK_CLEAR_ENABLE_I),
		.INTEGRATION_OSC_ENABLE_I(INTEGRATION_OSC_ENABLE_I), .OSC_RUN_IN_STOP_I(OSC_RUN_IN_STOP_I),
		.OSC_ENABLE_O(OSC_ENABLE_O), .PLL_ENABLE_O(PLL_ENABLE_O), .CRYSTAL_CLOCK_OUT_O(CRYSTAL_CLOCK_OUT_O),
		.DIVIDED_REFERENCE_CLOCK_O(DIVIDED_REFERENCE_CLOCK_O), .VCO_FEEDBACK_CLOCK_O(VCO_FEEDBACK_CLOCK_O),
		.GENERATOR_OUTPUT_CLOCK_O(GENERATOR_OUTPUT_CLOCK_O), .OUTPUT_FROM_VCO_O(OUTPUT_FROM_VCO_O),
		.TRACKING_O(TRACKING_O), .LOCK_IRQ_O(LOCK_IRQ_O), .VCO_RANGE_VALUE_O(VCO_RANGE_VALUE_O),
		.VCO_RANGE_POWER_O(VCO_RANGE_POWER_O)
	);
	pcg_xtal_model #(.PERIOD(4)) pcg_xtal_model_inst (.clk_i(CLK_I), .en_i(OSC_ENABLE_O), .tick_o(XTAL_TICK_I));

	initial forever #10 CLK_I = ~CLK_I;
	// VCO runs at half the system clock
	always @(posedge CLK_I) VCO_TICK_I <= ~VCO_TICK_I;
	always @(posedge CLK_I)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= v;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1;
		v = RDATA_O;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		`CHK($sformatf("reg %0h", a), e, v)
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge CLK_I);
		#1;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return DIVIDED_REFERENCE_CLOCK_O;
			1: return VCO_FEEDBACK_CLOCK_O;
			2: return GENERATOR_OUTPUT_CLOCK_O;
			default: return CRYSTAL_CLOCK_OUT_O;
		endcase
	endfunction

	// Cycles between two rising edges of a clock output, 0 if none within 200 cycles
	task automatic meas(input int s, output int r);
		int c, t0;
		logic p, q;
		c = 0;
		t0 = -1;
		r = 0;
		p = sig(s);
		while (c < 200 && r == 0)
		begin
			@(posedge CLK_I);
			#1;
			q = sig(s);
			if (q === 1'b1 && p === 1'b0)
			begin
				if (t0 < 0)
					t0 = c;
				else
					r = c - t0;
			end
			p = q;
			c++;
		end
	endtask

	task give_verdict;
		$display("Checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(8'(8'h36 + i), RST_TBL[i]);
		wr(8'h3C, 8'hFF);
		rchk(8'h3C, 8'h00);
		wr(8'h39, 8'h55);
		rchk(8'h39, 8'h40);
		wr(8'h36, 8'h80);
		rchk(8'h36, 8'h00);
		wr(8'h36, 8'h05);
		rchk(8'h36, 8'h05);
		wr(8'h38, 8'hF0);
		wr(8'h39, 8'h05);
		// Reference divided by three keeps the compare clock in its intended range
		wr(8'h3B, 8'hF3);
		wr(8'h3A, 8'h00);
		rchk(8'h38, 8'h00);
		rchk(8'h39, 8'h05);
		rchk(8'h3B, 8'h03);
		wr(8'h36, 8'h15);
		rchk(8'h36, 8'h05);
		wr(8'h36, 8'h25);
		// Dividers only run with the loop powered
		meas(0, n);
		`CHK("ref period", 12, n)
		meas(2, n);
		`CHK("xtal out period", 8, n)
		meas(3, n);
		`CHK("crystal period", 4, n)
		wr(8'h36, 8'h35);
		rchk(8'h36, 8'h25);
		wr(8'h3A, 8'h40);
		rchk(8'h3A, 8'h00);
		wr(8'h36, 8'h05);
		wr(8'h3A, 8'h40);
		wr(8'h36, 8'h25);
		wr(8'h36, 8'h35);
		rchk(8'h36, 8'h35);
		wr(8'h36, 8'h15);
		rchk(8'h36, 8'h35);
		wt(10);
		`CHK("from vco", 1'b1, OUTPUT_FROM_VCO_O)
		`CHK("range value", 8'h40, VCO_RANGE_VALUE_O)
		`CHK("range power", 2'h1, VCO_RANGE_POWER_O)
		meas(2, n);
		`CHK("vco out period", 4, n)
		meas(1, n);
		`CHK("feedback period", 20, n)
		@(posedge CLK_I) STOP_I <= 1'b1;
		wt(4);
		`CHK("osc en", 1'b0, OSC_ENABLE_O)
		`CHK("pll en", 1'b0, PLL_ENABLE_O)
		meas(2, n);
		`CHK("stop edges", 0, n)
		meas(3, n);
		`CHK("stop xtal edges", 0, n)
		rchk(8'h36, 8'h25);
		@(posedge CLK_I) OSC_RUN_IN_STOP_I <= 1'b1;
		wt(4);
		`CHK("osc en", 1'b1, OSC_ENABLE_O)
		`CHK("pll en", 1'b0, PLL_ENABLE_O)
		@(posedge CLK_I)
		begin
			STOP_I <= 1'b0;
			OSC_RUN_IN_STOP_I <= 1'b0;
			INTEGRATION_OSC_ENABLE_I <= 1'b0;
		end
		wt(4);
		`CHK("osc en", 1'b0, OSC_ENABLE_O)
		@(posedge CLK_I) OSC_RUN_IN_STOP_I <= 1'b1;
		wt(4);
		`CHK("osc en", 1'b1, OSC_ENABLE_O)
		@(posedge CLK_I)
		begin
			OSC_RUN_IN_STOP_I <= 1'b0;
			INTEGRATION_OSC_ENABLE_I <= 1'b1;
			LOCK_I <= 1'b1;
		end
		wt(4);
		rchk(8'h37, 8'h00);
		wr(8'h37, 8'h20);
		rchk(8'h37, 8'h20);
		`CHK("tracking", 1'b1, TRACKING_O)
		wr(8'h37, 8'h80);
		wt(3);
		rchk(8'h37, 8'hE0);
		rchk(8'h36, 8'h25);
		@(posedge CLK_I) LOCK_I <= 1'b0;
		wr(8'h37, 8'hA0);
		rchk(8'h37, 8'h80);
		wr(8'h36, 8'hA5);
		wt(2);
		`CHK("lock irq", 1'b1, LOCK_IRQ_O)
		rchk(8'h36, 8'hE5);
		rchk(8'h36, 8'hA5);
		`CHK("lock irq", 1'b0, LOCK_IRQ_O)
		@(posedge CLK_I)
		begin
			BREAK_I <= 1'b1;
			LOCK_I <= 1'b1;
		end
		wt(3);
		rchk(8'h36, 8'hE5);
		rchk(8'h36, 8'hE5);
		@(posedge CLK_I) BREAK_CLEAR_ENABLE_I <= 1'b1;
		rchk(8'h36, 8'hE5);
		rchk(8'h36, 8'hA5);
		@(posedge CLK_I) BREAK_I <= 1'b0;
		wr(8'h37, 8'h00);
		rchk(8'h36, 8'h25);
		give_verdict();
	end
endmodule
